// file: verilog/ttcr_timer.sv
module ttcr_timer import ttcr_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,

  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,

  // external inputs
  input wire logic count_input,
  input wire logic trigger_input,

  // serial port clocking
  input wire logic timer1_ovf,
  output logic ovf_pulse,
  output logic rx_baud_tick,
  output logic tx_baud_tick,

  // interrupt request to the cpu
  output logic timer_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] presc;
    logic [15:0] count;
    logic [15:0] cap;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic ovf;
  } ttcr_state_s;

  ttcr_state_s st_q;
  ttcr_state_s st_d;

  logic [1:0] fall;
  logic cnt_fall;
  logic trig_fall;

  ttcr_mode_e mode;
  logic tick;
  logic advance;
  logic rollover;
  logic trig;
  logic [15:0] count_inc;

  // ----------------------------------------------------------------
  // falling-edge detection of the external inputs
  // ----------------------------------------------------------------
  ttcr_edge #(
    .N(2)
  ) u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .level_in({trigger_input, count_input}),
    .fall_pulse(fall)
  );

  assign cnt_fall = fall[0];
  assign trig_fall = fall[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q.presc <= TTCR_PRESC_RST;
      st_q.count <= TTCR_COUNT_RST;
      st_q.cap <= TTCR_CAP_RST;
      st_q.ctrl <= TTCR_CONTROL_RST;
      st_q.rdata <= 8'h00;
      st_q.ovf <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // count source and mode decode
  // ----------------------------------------------------------------
  always_comb begin
    mode = ttcr_mode_of(st_q.ctrl);
    // prescaler runs free so the osc/12 phase is not tied to run_bit
    if (st_q.ctrl[TTCR_BIT_CSEL]) begin
      tick = cnt_fall;
    end else begin
      tick = (st_q.presc == TTCR_PRESC_LAST);
    end
    advance = (mode != TTCR_MODE_OFF) && tick;
    rollover = advance && (st_q.count == TTCR_COUNT_MAX);
    // trigger edges are dropped while off or clocking the serial port
    trig = trig_fall && st_q.ctrl[TTCR_BIT_EXEN] &&
           ((mode == TTCR_MODE_RELOAD) ||
            (mode == TTCR_MODE_CAPTURE));
    count_inc = st_q.count + 16'h0001;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.ovf = 1'b0;

    if (st_q.presc == TTCR_PRESC_LAST) begin
      st_d.presc = TTCR_PRESC_RST;
    end else begin
      st_d.presc = st_q.presc + 4'h1;
    end

    // software writes first; hardware events below take precedence
    if (sfr_wr) begin
      if (sfr_addr == TTCR_ADDR_CONTROL) begin
        st_d.ctrl = sfr_wdata;
      end else if (sfr_addr == TTCR_ADDR_CAP_LO) begin
        st_d.cap[7:0] = sfr_wdata;
      end else if (sfr_addr == TTCR_ADDR_CAP_HI) begin
        st_d.cap[15:8] = sfr_wdata;
      end
    end

    case (mode)
      TTCR_MODE_CAPTURE: begin
        if (advance) begin
          st_d.count = count_inc;
        end
        if (rollover) begin
          st_d.ctrl[TTCR_BIT_OVF] = 1'b1;
          st_d.ovf = 1'b1;
        end
        if (trig) begin
          st_d.cap = st_q.count;
          st_d.ctrl[TTCR_BIT_EXF] = 1'b1;
        end
      end
      TTCR_MODE_RELOAD: begin
        if (rollover || trig) begin
          st_d.count = st_q.cap;
        end else if (advance) begin
          st_d.count = count_inc;
        end
        if (rollover) begin
          st_d.ctrl[TTCR_BIT_OVF] = 1'b1;
          st_d.ovf = 1'b1;
        end
        if (trig) begin
          st_d.ctrl[TTCR_BIT_EXF] = 1'b1;
        end
      end
      TTCR_MODE_BAUD: begin
        // overflow_flag is left alone here, only the pulse goes out
        if (rollover) begin
          st_d.count = st_q.cap;
          st_d.ovf = 1'b1;
        end else if (advance) begin
          st_d.count = count_inc;
        end
      end
      default: begin
        st_d.count = st_q.count;
      end
    endcase

    // a count byte write wins over the hardware update of that byte
    if (sfr_wr) begin
      if (sfr_addr == TTCR_ADDR_CNT_LO) begin
        st_d.count[7:0] = sfr_wdata;
      end else if (sfr_addr == TTCR_ADDR_CNT_HI) begin
        st_d.count[15:8] = sfr_wdata;
      end
    end

    // register reads are answered one cycle after the strobe
    if (sfr_rd) begin
      if (sfr_addr == TTCR_ADDR_CONTROL) begin
        st_d.rdata = st_q.ctrl;
      end else if (sfr_addr == TTCR_ADDR_CNT_LO) begin
        st_d.rdata = st_q.count[7:0];
      end else if (sfr_addr == TTCR_ADDR_CNT_HI) begin
        st_d.rdata = st_q.count[15:8];
      end else if (sfr_addr == TTCR_ADDR_CAP_LO) begin
        st_d.rdata = st_q.cap[7:0];
      end else if (sfr_addr == TTCR_ADDR_CAP_HI) begin
        st_d.rdata = st_q.cap[15:8];
      end else begin
        st_d.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = st_q.rdata;
  assign ovf_pulse = st_q.ovf;

  // flags only fall by software writes, so the request holds until then
  assign timer_irq = st_q.ctrl[TTCR_BIT_OVF] ||
                     st_q.ctrl[TTCR_BIT_EXF];

  // the serial port uses these ticks only in its modes 1 and 3
  assign rx_baud_tick = st_q.ctrl[TTCR_BIT_RCLK] ? st_q.ovf :
                        timer1_ovf;
  assign tx_baud_tick = st_q.ctrl[TTCR_BIT_TRANSMIT_CLOCK_SELECT] ? st_q.ovf :
                        timer1_ovf;

endmodule : ttcr_timer

// file: verilog/ttcr_pkg.sv
// Operation
// - 16-bit count from low and high bytes
// - counter_select picks osc/12 or count edges
// - run_bit gates all counting
// - capture_reload_select picks capture or reload
// - capture mode overflow sets overflow_flag
// - trigger edge copies count into capture bytes
// - capture trigger sets external_flag, may interrupt
// - reload mode rollover sets flag, reloads count
// - reload mode trigger edge forces reload, flag
// - clock-select bits force baud-rate auto-reload
// - no overflow_flag in baud mode; software clears
// - external_flag interrupts until software clears
// - receive clock select routes rx baud tick
// - transmit clock select routes tx baud tick
// - trigger edges need enable, not baud mode
// - control bit positions 7 down to 0
package ttcr_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special function port
  // ----------------------------------------------------------------
  localparam logic [7:0] TTCR_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] TTCR_ADDR_CNT_LO = 8'h01;
  localparam logic [7:0] TTCR_ADDR_CNT_HI = 8'h02;
  localparam logic [7:0] TTCR_ADDR_CAP_LO = 8'h03;
  localparam logic [7:0] TTCR_ADDR_CAP_HI = 8'h04;

  // ----------------------------------------------------------------
  // timer_three_control fields
  // ----------------------------------------------------------------
  localparam int TTCR_BIT_OVF = 7;
  localparam int TTCR_BIT_EXF = 6;
  localparam int TTCR_BIT_RCLK = 5;
  localparam int TTCR_BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int TTCR_BIT_EXEN = 3;
  localparam int TTCR_BIT_RUN = 2;
  localparam int TTCR_BIT_CSEL = 1;
  localparam int TTCR_BIT_CPRL = 0;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] TTCR_CONTROL_RST = 8'h00;
  localparam logic [15:0] TTCR_COUNT_RST = 16'h0000;
  localparam logic [15:0] TTCR_CAP_RST = 16'h0000;
  localparam logic [15:0] TTCR_COUNT_MAX = 16'hFFFF;
  localparam int TTCR_OSC_DIV = 12;
  localparam logic [3:0] TTCR_PRESC_LAST = 4'(TTCR_OSC_DIV - 1);
  localparam logic [3:0] TTCR_PRESC_RST = 4'h0;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TTCR_MODE_OFF = 4'b0001,
    TTCR_MODE_RELOAD = 4'b0010,
    TTCR_MODE_CAPTURE = 4'b0100,
    TTCR_MODE_BAUD = 4'b1000
  } ttcr_mode_e;

  function automatic ttcr_mode_e ttcr_mode_of(input logic [7:0] ctrl);
    if (!ctrl[TTCR_BIT_RUN]) begin
      return TTCR_MODE_OFF;
    end else if (ctrl[TTCR_BIT_RCLK] || ctrl[TTCR_BIT_TRANSMIT_CLOCK_SELECT]) begin
      return TTCR_MODE_BAUD;
    end else if (ctrl[TTCR_BIT_CPRL]) begin
      return TTCR_MODE_CAPTURE;
    end else begin
      return TTCR_MODE_RELOAD;
    end
  endfunction : ttcr_mode_of

endpackage : ttcr_pkg

// file: verilog/ttcr_edge.sv
module ttcr_edge import ttcr_pkg::*; #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sampled inputs and their falling-edge events
  input wire logic [N-1:0] level_in,
  output logic [N-1:0] fall_pulse
);

  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] fall;
  } ttcr_edge_s;

  ttcr_edge_s st_q;
  ttcr_edge_s st_d;

  // previous sample starts high so a low level at reset counts as an edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '{prev: '1, fall: '0};
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.prev = level_in;
    st_d.fall = '0;
    for (int i = 0; i < N; i++) begin
      st_d.fall[i] = st_q.prev[i] && !level_in[i];
    end
  end

  assign fall_pulse = st_q.fall;

endmodule : ttcr_edge

// file: verif/ttcr_partner.sv
module ttcr_partner (
  // clock
  input wire logic clk_sys,
  // external inputs and second-timer overflow
  output logic count_input,
  output logic trigger_input,
  output logic timer1_ovf
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------
  // far-side drivers
  // ----------------------------
  // inputs rest at their idle levels between events
  task automatic idle();
    count_input = 1'b1;
    trigger_input = 1'b1;
    timer1_ovf = 1'b0;
  endtask : idle
  initial idle();
  // two cycles low then two high, so no fall is merged
  task automatic fall(input logic trg);
    @(negedge clk_sys);
    trigger_input = !trg;
    count_input = trg;
    repeat (2) @(negedge clk_sys);
    trigger_input = 1'b1;
    count_input = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask : fall
  // one-cycle pulse, as the second timer gives it
  task automatic t1_tick();
    @(negedge clk_sys);
    timer1_ovf = 1'b1;
    @(negedge clk_sys);
    timer1_ovf = 1'b0;
  endtask : t1_tick
endmodule : ttcr_partner

// file: verif/ttcr_timer_chk.sv
module ttcr_timer_chk import ttcr_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // external inputs, serial clocking, interrupt
  input wire logic count_input,
  input wire logic trigger_input,
  input wire logic timer1_ovf,
  input wire logic ovf_pulse,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic timer_irq
);
  // ----------------------------
  // control shadow and checks
  // ----------------------------
  // flag bits are set by hardware, so only bits 5..0 are trusted
  logic [7:0] ctrl_q;
  logic ctl_wr;
  logic baud_sel;
  assign ctl_wr = sfr_wr && sfr_addr == TTCR_ADDR_CONTROL;
  assign baud_sel = ctrl_q[TTCR_BIT_RCLK] || ctrl_q[TTCR_BIT_TRANSMIT_CLOCK_SELECT];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= TTCR_CONTROL_RST;
    end else if (ctl_wr) begin
      ctrl_q <= sfr_wdata;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_rx_route: assert property (
    rx_baud_tick == (ctrl_q[TTCR_BIT_RCLK] ? ovf_pulse : timer1_ovf))
    else $error("rx tick source wrong");
  a_tx_route: assert property (
    tx_baud_tick == (ctrl_q[TTCR_BIT_TRANSMIT_CLOCK_SELECT] ? ovf_pulse : timer1_ovf))
    else $error("tx tick source wrong");
  a_ovf_single: assert property (ovf_pulse |=> !ovf_pulse)
    else $error("overflow pulse too long");
  a_ovf_flag: assert property (
    ovf_pulse && !baud_sel && !$past(baud_sel) |-> timer_irq)
    else $error("overflow left irq low");
  a_baud_no_flag: assert property (
    ovf_pulse && $past(baud_sel) && !$past(timer_irq) && !$past(sfr_wr)
    |-> !timer_irq) else $error("baud overflow raised irq");
  a_irq_sticky: assert property (timer_irq && !ctl_wr |=> timer_irq)
    else $error("irq dropped by hardware");
  a_irq_cause: assert property ($rose(timer_irq) |-> ovf_pulse ||
    $past(sfr_wr) || ($past(trigger_input, 3) && !$past(trigger_input, 2)))
    else $error("irq without cause");
  a_stop_idle: assert property (
    !ctrl_q[TTCR_BIT_RUN] && !$past(ctrl_q[TTCR_BIT_RUN]) |-> !ovf_pulse)
    else $error("overflow while stopped");
  a_ctrl_read: assert property (
    $past(sfr_rd) && $past(sfr_addr) == TTCR_ADDR_CONTROL
    |-> sfr_rdata[5:0] == 6'($past(ctrl_q))) else $error("control bits");
endmodule : ttcr_timer_chk
bind ttcr_timer ttcr_timer_chk i_ttcr_timer_chk (.clk_sys(clk_sys),
  .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .count_input(count_input),
  .trigger_input(trigger_input), .timer1_ovf(timer1_ovf),
  .ovf_pulse(ovf_pulse), .rx_baud_tick(rx_baud_tick),
  .tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));

// file: verif/tb_top.sv
module tb_top import ttcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  int rx_n = 0;
  int tx_n = 0;
  logic [7:0] sfr_rdata;
  logic count_input, trigger_input, timer1_ovf;
  logic ovf_pulse, rx_baud_tick, tx_baud_tick, timer_irq;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  always #12.5 clk_sys = !clk_sys;
  ttcr_timer i_ttcr_timer (.clk_sys(clk_sys), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .count_input(count_input),
    .trigger_input(trigger_input), .timer1_ovf(timer1_ovf),
    .ovf_pulse(ovf_pulse), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));
  ttcr_partner i_ttcr_partner (.clk_sys(clk_sys),
    .count_input(count_input), .trigger_input(trigger_input),
    .timer1_ovf(timer1_ovf));
  // ticks are sampled 6ns after the rising edge, clear of both clock edges
  always @(posedge clk_sys) begin
    #6;
    if (rx_baud_tick === 1'b1) begin
      rx_n++;
    end
    if (tx_baud_tick === 1'b1) begin
      tx_n++;
    end
  end
  // ----------------------------
  // access and compare tasks
  // ----------------------------
  task automatic bus_idle();
    sfr_addr = TTCR_ADDR_CONTROL;
    sfr_wdata = TTCR_CONTROL_RST;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask : bus_idle
  task automatic complete_run();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // strobes rise and fall on falling edges, taken at the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask : rd
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask : w16
  task automatic r16(input logic [7:0] a, input logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
  endtask : r16
  task automatic ovf_wait(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk_sys);
      cyc++;
    end while (ovf_pulse !== 1'b1 && cyc < 2000);
  endtask : ovf_wait
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    #100us;
    err_count++;
    complete_run();
  end
  initial begin
    bus_idle();
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 0; a < 6; a++) rd(8'(a), 8'h00);
    wr(TTCR_ADDR_CONTROL, 8'h0B);
    i_ttcr_partner.fall(1'b1);
    rd(TTCR_ADDR_CONTROL, 8'h0B);
    w16(TTCR_ADDR_CNT_LO, 16'h12FE);
    wr(TTCR_ADDR_CONTROL, 8'h0F);
    repeat (3) i_ttcr_partner.fall(1'b0);
    r16(TTCR_ADDR_CNT_LO, 16'h1301);
    i_ttcr_partner.fall(1'b1);
    r16(TTCR_ADDR_CAP_LO, 16'h1301);
    rd(TTCR_ADDR_CONTROL, 8'h4F);
    wr(TTCR_ADDR_CONTROL, 8'h0F);
    chk({7'h00, timer_irq}, 8'h00);
    w16(TTCR_ADDR_CNT_LO, 16'hFFFF);
    i_ttcr_partner.fall(1'b0);
    r16(TTCR_ADDR_CNT_LO, 16'h0000);
    rd(TTCR_ADDR_CONTROL, 8'h8F);
    chk({7'h00, timer_irq}, 8'h01);
    w16(TTCR_ADDR_CAP_LO, 16'h1234);
    wr(TTCR_ADDR_CONTROL, 8'h06);
    w16(TTCR_ADDR_CNT_LO, 16'hFFFF);
    i_ttcr_partner.fall(1'b0);
    r16(TTCR_ADDR_CNT_LO, 16'h1234);
    i_ttcr_partner.fall(1'b1);
    rd(TTCR_ADDR_CONTROL, 8'h86);
    w16(TTCR_ADDR_CNT_LO, 16'h0050);
    wr(TTCR_ADDR_CONTROL, 8'h0E);
    i_ttcr_partner.fall(1'b1);
    r16(TTCR_ADDR_CNT_LO, 16'h1234);
    rd(TTCR_ADDR_CONTROL, 8'h4E);
    // trigger first: a wrong capture or reload would both show
    wr(TTCR_ADDR_CONTROL, 8'h3F);
    w16(TTCR_ADDR_CNT_LO, 16'hFFFF);
    i_ttcr_partner.fall(1'b1);
    i_ttcr_partner.fall(1'b0);
    i_ttcr_partner.t1_tick();
    r16(TTCR_ADDR_CNT_LO, 16'h1234);
    r16(TTCR_ADDR_CAP_LO, 16'h1234);
    rd(TTCR_ADDR_CONTROL, 8'h3F);
    chk(8'(rx_n), 8'h01);
    chk(8'(tx_n), 8'h01);
    w16(TTCR_ADDR_CAP_LO, 16'hFFFE);
    w16(TTCR_ADDR_CNT_LO, 16'hFFFF);
    wr(TTCR_ADDR_CONTROL, 8'h04);
    ovf_wait(n);
    ovf_wait(n);
    chk(8'(n), 8'h18);
    wr(TTCR_ADDR_CONTROL, 8'h10);
    i_ttcr_partner.t1_tick();
    rd(TTCR_ADDR_CONTROL, 8'h10);
    chk(8'(rx_n), 8'h02);
    chk(8'(tx_n), 8'h01);
    complete_run();
  end
endmodule : tb_top
